/* rtl/rci_params.svh */
`ifndef RCI_PARAMS_SVH
`define RCI_PARAMS_SVH

// System clock and the millisecond figures that the port timing is built on.
`define RCI_CLK_HZ 40000000
`define RCI_MS_DIV 1000
`define RCI_END_MS 100
`define RCI_RST_MS 100
`define RCI_DEB_MS 1

// Register byte addresses.
`define RCI_A_CTRL 8'h00
`define RCI_A_WORK 8'h04
`define RCI_A_STAT 8'h08
`define RCI_A_ISTAT 8'h0c
`define RCI_A_IMASK 8'h10

// Field positions.
`define RCI_CTRL_HEAT 0
`define RCI_WK_AUXO 6:0
`define RCI_WK_AUXI 12:8
`define RCI_ST_PROG 6:0
`define RCI_ST_READY 7
`define RCI_ST_RUN 8
`define RCI_ST_ERR 9
`define RCI_ST_STATE 14:12
`define RCI_ST_AUXI 20:16
`define RCI_IRQ_END 0
`define RCI_IRQ_ERR 1
`define RCI_IRQ_ESTOP 2
`define RCI_IRQ_W 3

// Reset values.
`define RCI_CTRL_RST 1'b0
`define RCI_AUXO_RST 7'h00
`define RCI_AUXI_RST 5'h00
`define RCI_IRQ_RST 3'h0

`endif

/* rtl/rci_pkg.sv */
package rci_pkg;

    typedef enum logic [2:0] {
        ST_UNHOMED,
        ST_HOMING,
        ST_READY,
        ST_RUN,
        ST_PAUSED,
        ST_ERROR,
        ST_ESTOP
    } rci_state_t;

    // Port pins as they arrive from the controller, all active high.
    typedef struct packed {
        logic [6:0] prog_sel;
        logic home;
        logic start;
        logic pstop;
        logic reset_req;
        logic [4:0] aux_in;
        logic loop_ok;
    } rci_pins_t;

    typedef struct packed {
        logic ready;
        logic running;
        logic end_pulse;
        logic error;
    } rci_sys_out_t;

endpackage : rci_pkg

/* rtl/rci_debounce.sv */
module rci_debounce #(
    parameter int W = 1,
    parameter int CYC = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] clean
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] snap;
    logic [31:0] cnt;
    wire tick = (cnt == 32'(CYC - 1));
    wire [W-1:0] differ = sync ^ snap;
    // A bit moves only when two samples one period apart agree.
    wire [W-1:0] next_clean = tick ? ((sync & ~differ) | (clean & differ)) : clean;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            sync <= '0;
            snap <= '0;
            cnt <= '0;
            clean <= '0;
        end else begin
            meta <= raw;
            sync <= meta;
            cnt <= tick ? 32'd0 : cnt + 32'd1;
            if (tick) begin
                snap <= sync;
            end
            clean <= next_clean;
        end
    end
endmodule : rci_debounce

/* rtl/rci_pulse_timer.sv */
module rci_pulse_timer #(
    parameter int CYC = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fire,
    output logic q
);
    logic [31:0] cnt;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= 1'b0;
            cnt <= '0;
        end else if (fire) begin
            q <= 1'b1;
            cnt <= 32'(CYC - 1);
        end else if (cnt != 32'd0) begin
            cnt <= cnt - 32'd1;
        end else begin
            q <= 1'b0;
        end
    end
endmodule : rci_pulse_timer

/* rtl/rci_cycle_io.sv */
// Chosen here: the register offsets and the APB interface to the registers.
`include "rci_params.svh"

// Summary of operation
// - Program number is binary sum of selects
// - Accepted start begins selected program run
// - Ready is high when start is taken
// - Partial stop halts before next step
// - Axes stop at once, soldering finishes
// - Reset leaves emergency or error state
// - Aux inputs sampled per work parameters
// - Ready high whenever start is allowed
// - Running high throughout automatic run
// - One 100 ms end pulse per run
// - Error set on fault, held until recovery
// - Error clears by reset then homing
// - Seven general outputs
// - General outputs follow work parameters
// - Open loop halts all, heater off
module rci_cycle_io
    import rci_pkg::*;
#(
    parameter int END_CYC = `RCI_END_MS * (`RCI_CLK_HZ / `RCI_MS_DIV),
    parameter int RST_CYC = `RCI_RST_MS * (`RCI_CLK_HZ / `RCI_MS_DIV),
    parameter int DEB_CYC = `RCI_DEB_MS * (`RCI_CLK_HZ / `RCI_MS_DIV)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire rci_pins_t pins,
    output rci_sys_out_t sys_out,
    output logic [6:0] aux_out,
    output logic [6:0] prog_num,
    output logic step_req,
    input wire logic step_done,
    input wire logic step_solder,
    input wire logic step_last,
    output logic home_cmd,
    input wire logic home_done,
    input wire logic fault,
    output logic axis_stop,
    output logic heater_en
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    rci_pins_t pin_c;
    rci_state_t state;
    rci_state_t next_state;
    logic start_d;
    logic home_d;
    logic rst_d;
    logic [31:0] rst_cnt;
    logic heat_req;
    logic [6:0] wk_auxo;
    logic [4:0] wk_auxi;
    logic [4:0] aux_smp;
    logic [`RCI_IRQ_W-1:0] irq_stat;
    logic [`RCI_IRQ_W-1:0] irq_mask;
    logic end_q;
    logic [31:0] rd_mux;
    logic hit;

    rci_debounce #(
        .W($bits(rci_pins_t)),
        .CYC(DEB_CYC)
    ) u_deb (
        .clk(clk),
        .arst_n(arst_n),
        .raw(pins),
        .clean(pin_c)
    );

    wire start_rise = pin_c.start & ~start_d;
    wire home_rise = pin_c.home & ~home_d;
    wire loop_open = ~pin_c.loop_ok;
    // A reset press counts once, after it has been held for the full time.
    wire rst_ok = pin_c.reset_req & (rst_cnt == 32'(RST_CYC - 1));
    wire [31:0] next_rst_cnt = !pin_c.reset_req ? 32'd0 :
                               (rst_cnt == 32'(RST_CYC)) ? rst_cnt : rst_cnt + 32'd1;

    always_comb begin
        next_state = state;
        case (state)
            ST_UNHOMED: begin
                if (home_rise) begin
                    next_state = ST_HOMING;
                end
            end
            ST_HOMING: begin
                if (home_done) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (start_rise) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (step_done && step_last) begin
                    next_state = ST_READY;
                end else if (step_done && pin_c.pstop) begin
                    next_state = ST_PAUSED;
                end
            end
            ST_PAUSED: begin
                if (start_rise) begin
                    next_state = ST_RUN;
                end else if (home_rise) begin
                    next_state = ST_HOMING;
                end
            end
            ST_ERROR: begin
                if (rst_ok) begin
                    next_state = ST_UNHOMED;
                end
            end
            ST_ESTOP: begin
                if (rst_ok) begin
                    next_state = ST_UNHOMED;
                end
            end
            default: begin
                next_state = ST_UNHOMED;
            end
        endcase
        // The loop outranks every other cause, and the state is held while it is open.
        if (loop_open) begin
            next_state = ST_ESTOP;
        end else if (fault && state != ST_ESTOP && state != ST_ERROR) begin
            next_state = ST_ERROR;
        end
    end

    wire go_step = (next_state == ST_RUN) && (state != ST_RUN || step_done);
    wire run_done = (state == ST_RUN) && step_done && step_last && (next_state == ST_READY);
    wire err_set = (next_state == ST_ERROR) && (state != ST_ERROR);
    wire estop_set = (next_state == ST_ESTOP) && (state != ST_ESTOP);
    // Any homing that completes with the loop closed and no fault present clears the flag.
    wire err_clr = (state == ST_HOMING) && home_done && !loop_open && !fault;
    wire [`RCI_IRQ_W-1:0] irq_ev = {estop_set, err_set, run_done};
    // Axes halt at once, but a soldering step in flight is left to finish.
    wire next_axis_stop = ((state == ST_RUN) && pin_c.pstop && !step_solder) ||
                          (next_state == ST_ESTOP) || (next_state == ST_ERROR);

    // Register bus.
    wire acc = psel & penable & ~pready;
    wire wr = acc & pwrite;
    wire wr_ctrl = wr && (paddr == `RCI_A_CTRL);
    wire wr_work = wr && (paddr == `RCI_A_WORK);
    wire wr_istat = wr && (paddr == `RCI_A_ISTAT);
    wire wr_imask = wr && (paddr == `RCI_A_IMASK);
    wire [31:0] ctrl_word = {31'd0, heat_req};
    wire [31:0] work_word = {19'd0, wk_auxi, 1'b0, wk_auxo};
    wire [31:0] istat_word = {29'd0, irq_stat};
    wire [31:0] imask_word = {29'd0, irq_mask};
    wire [31:0] ctrl_new = merge(ctrl_word, pwdata, pstrb);
    wire [31:0] work_new = merge(work_word, pwdata, pstrb);
    wire [31:0] imask_new = merge(imask_word, pwdata, pstrb);
    wire [31:0] w1c = merge(32'd0, pwdata, pstrb);
    wire [`RCI_IRQ_W-1:0] clr = wr_istat ? w1c[`RCI_IRQ_W-1:0] : `RCI_IRQ_RST;
    // A new event wins over a clear written in the same cycle.
    wire [`RCI_IRQ_W-1:0] next_irq_stat = (irq_stat & ~clr) | irq_ev;
    wire [`RCI_IRQ_W-1:0] next_irq_mask = wr_imask ? imask_new[`RCI_IRQ_W-1:0] : irq_mask;

    logic [31:0] stat_word;
    always_comb begin
        stat_word = '0;
        stat_word[`RCI_ST_PROG] = prog_num;
        stat_word[`RCI_ST_READY] = sys_out.ready;
        stat_word[`RCI_ST_RUN] = sys_out.running;
        stat_word[`RCI_ST_ERR] = sys_out.error;
        stat_word[`RCI_ST_STATE] = state;
        stat_word[`RCI_ST_AUXI] = aux_smp;
    end

    always_comb begin
        hit = 1'b1;
        if (paddr == `RCI_A_CTRL) begin
            rd_mux = ctrl_word;
        end else if (paddr == `RCI_A_WORK) begin
            rd_mux = work_word;
        end else if (paddr == `RCI_A_STAT) begin
            rd_mux = stat_word;
        end else if (paddr == `RCI_A_ISTAT) begin
            rd_mux = istat_word;
        end else if (paddr == `RCI_A_IMASK) begin
            rd_mux = imask_word;
        end else begin
            rd_mux = '0;
            hit = 1'b0;
        end
    end

    rci_pulse_timer #(
        .CYC(END_CYC)
    ) u_end (
        .clk(clk),
        .arst_n(arst_n),
        .fire(run_done),
        .q(end_q)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_UNHOMED;
            start_d <= 1'b0;
            home_d <= 1'b0;
            rst_cnt <= '0;
        end else begin
            state <= next_state;
            start_d <= pin_c.start;
            home_d <= pin_c.home;
            rst_cnt <= next_rst_cnt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_out <= '0;
            prog_num <= '0;
            step_req <= 1'b0;
            home_cmd <= 1'b0;
            axis_stop <= 1'b0;
            heater_en <= 1'b0;
        end else begin
            sys_out.ready <= (next_state == ST_READY) || (next_state == ST_PAUSED);
            sys_out.running <= (next_state == ST_RUN);
            sys_out.end_pulse <= end_q;
            sys_out.error <= err_set | (sys_out.error & ~err_clr);
            if (state == ST_READY && go_step) begin
                prog_num <= pin_c.prog_sel;
            end
            step_req <= go_step;
            home_cmd <= (next_state == ST_HOMING);
            axis_stop <= next_axis_stop;
            heater_en <= heat_req && (next_state != ST_ESTOP);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            heat_req <= `RCI_CTRL_RST;
            wk_auxo <= `RCI_AUXO_RST;
            wk_auxi <= `RCI_AUXI_RST;
            aux_smp <= `RCI_AUXI_RST;
            aux_out <= `RCI_AUXO_RST;
            irq_stat <= `RCI_IRQ_RST;
            irq_mask <= `RCI_IRQ_RST;
            irq <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                heat_req <= ctrl_new[`RCI_CTRL_HEAT];
            end
            if (wr_work) begin
                wk_auxo <= work_new[`RCI_WK_AUXO];
                wk_auxi <= work_new[`RCI_WK_AUXI];
            end
            aux_smp <= pin_c.aux_in & wk_auxi;
            aux_out <= wk_auxo;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= |(next_irq_stat & next_irq_mask);
            pready <= acc;
            pslverr <= acc & ~hit;
            prdata <= (acc && !pwrite) ? rd_mux : 32'd0;
        end
    end

    // Checks.
    logic [31:0] end_len;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            end_len <= '0;
        end else begin
            end_len <= sys_out.end_pulse ? end_len + 32'd1 : 32'd0;
        end
    end

    wire calm = !loop_open && !fault;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_start_run: assert property (
        state == ST_READY && start_rise && calm |-> sys_out.ready ##1 (sys_out.running && step_req)
    ) else $error("accepted start did not begin a run");
    chk_ready_level: assert property (
        sys_out.ready == (state == ST_READY || state == ST_PAUSED)
    ) else $error("ready does not match startable state");
    chk_run_level: assert property (
        sys_out.running == (state == ST_RUN)
    ) else $error("running does not match run state");
    chk_end_width: assert property (
        $fell(sys_out.end_pulse) |-> end_len == 32'(END_CYC)
    ) else $error("end pulse has wrong length");
    chk_pstop_pause: assert property (
        state == ST_RUN && step_done && !step_last && pin_c.pstop && calm
        |=> state == ST_PAUSED && !step_req
    ) else $error("partial stop did not hold the next step");
    chk_axis_stop: assert property (
        state == ST_RUN && pin_c.pstop && !step_solder |=> axis_stop
    ) else $error("axes not stopped under partial stop");
    chk_estop_halt: assert property (
        loop_open |=> state == ST_ESTOP && !heater_en && !sys_out.running
    ) else $error("open loop did not halt and cut heater");
    chk_err_hold: assert property (
        state == ST_ERROR |-> sys_out.error
    ) else $error("error output low in error state");
    chk_err_clear: assert property (
        $fell(sys_out.error) |-> $past(state) == ST_HOMING && $past(home_done)
    ) else $error("error cleared other than by homing");
    chk_home_first: assert property (
        state == ST_UNHOMED && start_rise |=> !sys_out.running && !step_req
    ) else $error("start taken before homing");
    chk_prog_latch: assert property (
        state == ST_READY && start_rise && calm |=> prog_num == $past(pin_c.prog_sel)
    ) else $error("program number not taken at start");
    chk_reset_exit: assert property (
        state == ST_ERROR && rst_ok && calm |=> state == ST_UNHOMED
    ) else $error("reset did not leave error state");
    chk_aux_gate: assert property (
        (aux_smp & ~$past(wk_auxi)) == 5'h00
    ) else $error("disabled aux input sampled");
endmodule : rci_cycle_io

/* sim/rci_plc_model.sv */
module rci_plc_model
    import rci_pkg::*;
(
    input wire logic clk,
    output rci_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // Contacts are open between presses, so every line rests low.
    initial pins = '0;

    task automatic set_lvl(input int sel, input logic v);
        @(posedge clk);
        case (sel)
            0: pins.home <= v;
            1: pins.start <= v;
            2: pins.pstop <= v;
            3: pins.reset_req <= v;
            default: pins.loop_ok <= v;
        endcase
    endtask : set_lvl

    task automatic press(input int sel, input int cyc);
        set_lvl(sel, 1'b1);
        repeat (cyc) @(posedge clk);
        set_lvl(sel, 1'b0);
    endtask : press

    // Callers clear the cause first; the hold must beat the recognition time.
    task automatic clear_fault(input int cyc);
        press(3, cyc);
    endtask : clear_fault

    task automatic set_sel(input logic [6:0] v);
        @(posedge clk);
        pins.prog_sel <= v;
    endtask : set_sel

    task automatic set_aux(input logic [4:0] v);
        @(posedge clk);
        pins.aux_in <= v;
    endtask : set_aux
endmodule : rci_plc_model

/* sim/tb.sv */
`include "rci_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int END_C = 20;
    localparam int HOLD = 12;
    localparam int RST_C = 10;
    localparam int DEB_C = 2;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [16:0] pins;
    logic [3:0] sys_out;
    logic [6:0] aux_out, prog_num;
    logic step_req, home_cmd, axis_stop, heater_en;
    logic step_done = 1'b0;
    logic step_solder = 1'b0;
    logic step_last = 1'b0;
    logic home_done = 1'b0;
    logic fault = 1'b0;
    wire logic [8:0] obs = {irq, heater_en, axis_stop, home_cmd, step_req, sys_out};
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    rci_plc_model plc (.clk(clk), .pins(pins));
    rci_cycle_io #(.END_CYC(END_C), .RST_CYC(RST_C), .DEB_CYC(DEB_C)) uut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pins(pins), .sys_out(sys_out), .aux_out(aux_out),
        .prog_num(prog_num), .step_req(step_req), .step_done(step_done),
        .step_solder(step_solder), .step_last(step_last), .home_cmd(home_cmd),
        .home_done(home_done), .fault(fault), .axis_stop(axis_stop), .heater_en(heater_en)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic conclude;
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            conclude;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_out(input int idx, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            if (obs[idx] === v) break;
        end
        chk(32'(obs[idx]), 32'(v));
    endtask : wait_out

    task automatic stays(input int idx, input logic v, input int n);
        repeat (n) begin
            @(posedge clk);
            chk(32'(obs[idx]), 32'(v));
        end
    endtask : stays

    // Pready is sampled at the edge, so the access ends exactly where it is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // This wait has no limit of its own; it ends when pready is seen high, or at the bench timeout.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic state_is(input logic [2:0] s);
        apb(1'b0, `RCI_A_STAT, 32'h0);
        chk(32'(rd[`RCI_ST_STATE]), 32'(s));
    endtask : state_is

    task automatic pulse_done(input logic last);
        @(posedge clk);
        step_done <= 1'b1;
        step_last <= last;
        @(posedge clk);
        step_done <= 1'b0;
    endtask : pulse_done

    task automatic pulse_home;
        @(posedge clk);
        home_done <= 1'b1;
        @(posedge clk);
        home_done <= 1'b0;
    endtask : pulse_home

    task automatic t_boot;
        chk(32'(obs[7]), 32'h0);
        state_is(3'd6);
    endtask : t_boot

    task automatic t_recover;
        plc.set_lvl(4, 1'b1);
        repeat (10) @(posedge clk);
        plc.clear_fault(30);
        repeat (10) @(posedge clk);
        state_is(3'd0);
        plc.press(1, HOLD);
        stays(2, 1'b0, 10);
        plc.press(0, HOLD);
        wait_out(5, 1'b1, 5);
        chk(32'(obs[3]), 32'h0);
        pulse_home;
        wait_out(3, 1'b1, 5);
    endtask : t_recover

    task automatic t_aux;
        apb(1'b1, `RCI_A_WORK, 32'h1f55);
        repeat (2) @(posedge clk);
        chk(32'(aux_out), 32'h55);
        plc.set_aux(5'h15);
        repeat (10) @(posedge clk);
        apb(1'b0, `RCI_A_STAT, 32'h0);
        chk(32'(rd[`RCI_ST_AUXI]), 32'h15);
        apb(1'b1, `RCI_A_WORK, 32'h0a2a);
        repeat (2) @(posedge clk);
        chk(32'(aux_out), 32'h2a);
        apb(1'b0, `RCI_A_STAT, 32'h0);
        chk(32'(rd[`RCI_ST_AUXI]), 32'h00);
        // Only the low byte is enabled, so the input enables must survive.
        pstrb <= 4'h1;
        apb(1'b1, `RCI_A_WORK, 32'h1f7f);
        pstrb <= 4'hf;
        apb(1'b0, `RCI_A_WORK, 32'h0);
        chk(rd, 32'h0a7f);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(er), 32'h1);
    endtask : t_aux

    task automatic t_run;
        int n;
        apb(1'b1, `RCI_A_IMASK, 32'h1);
        plc.set_sel(7'd99);
        repeat (10) @(posedge clk);
        chk(32'(obs[3]), 32'h1);
        plc.set_lvl(1, 1'b1);
        wait_out(4, 1'b1, 15);
        chk(32'(obs[3:2]), 32'h1);
        chk(32'(prog_num), 32'd99);
        plc.set_lvl(1, 1'b0);
        pulse_done(1'b0);
        wait_out(4, 1'b1, 4);
        pulse_done(1'b1);
        wait_out(2, 1'b0, 4);
        wait_out(1, 1'b1, 4);
        n = 0;
        while (obs[1] === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n), 32'(END_C));
        wait_out(8, 1'b1, 5);
        apb(1'b1, `RCI_A_ISTAT, 32'h1);
        wait_out(8, 1'b0, 5);
    endtask : t_run

    task automatic t_pstop;
        plc.set_lvl(1, 1'b1);
        wait_out(4, 1'b1, 15);
        plc.set_lvl(1, 1'b0);
        step_solder <= 1'b1;
        plc.set_lvl(2, 1'b1);
        stays(6, 1'b0, 10);
        step_solder <= 1'b0;
        wait_out(6, 1'b1, 4);
        pulse_done(1'b0);
        stays(4, 1'b0, 5);
        chk(32'(obs[3]), 32'h1);
        state_is(3'd4);
        plc.set_lvl(2, 1'b0);
        repeat (10) @(posedge clk);
        plc.set_lvl(1, 1'b1);
        wait_out(4, 1'b1, 15);
        plc.set_lvl(1, 1'b0);
        pulse_done(1'b1);
        wait_out(2, 1'b0, 4);
    endtask : t_pstop

    task automatic t_fault;
        fault <= 1'b1;
        wait_out(0, 1'b1, 4);
        wait_out(6, 1'b1, 3);
        fault <= 1'b0;
        stays(0, 1'b1, 5);
        plc.clear_fault(30);
        repeat (10) @(posedge clk);
        chk(32'(obs[0]), 32'h1);
        plc.press(0, HOLD);
        wait_out(5, 1'b1, 5);
        pulse_home;
        wait_out(0, 1'b0, 5);
        wait_out(3, 1'b1, 5);
    endtask : t_fault

    task automatic t_estop;
        apb(1'b1, `RCI_A_CTRL, 32'h1);
        wait_out(7, 1'b1, 5);
        plc.set_lvl(4, 1'b0);
        wait_out(7, 1'b0, 15);
        state_is(3'd6);
    endtask : t_estop

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_boot;
        t_recover;
        t_aux;
        t_run;
        t_pstop;
        t_fault;
        t_estop;
        conclude;
    end
endmodule : tb
